//--- src/ddr_sram_burst2_bus_cycle.sv
// Bus cycle logic of the two-word burst DDR SRAM
`timescale 1ns/1ns
module ddr_sram_burst2_bus_cycle import ddr_burst2_pkg::*; #(
  parameter int DATA_W = DATA_W_DEF,
  parameter int ADDR_W = ADDR_W_DEF
) (
  input  wire logic                  sys_clk,          // 125 MHz clock
  input  wire logic                  sys_rst,          // Sync reset, high
  input  wire logic                  input_strobe_p,   // Input clock pin
  input  wire logic                  input_strobe_n,   // Input clock compl.
  input  wire logic                  output_strobe_p,  // Output clock pin
  input  wire logic                  output_strobe_n,  // Output clock compl.
  input  wire logic                  load_n,           // Cycle load, low
  input  wire logic                  read_not_write,   // High read, low write
  input  wire logic [ADDR_W-2:0]     addr_in,          // Upper address
  input  wire logic                  burst_low_bit,    // Lowest address bit
  input  wire logic [DATA_W/9-1:0]   lane_write_en_n,  // Lane enables, low
  input  wire logic [DATA_W-1:0]     dq_in,            // Data pin input
  output logic      [DATA_W-1:0]     dq_out,           // Data pin output
  output logic                       dq_oe,            // Data pin enable
  output logic                       return_strobe_p,  // Echo clock
  output logic                       return_strobe_n   // Echo clock compl.
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int LANES = DATA_W / LANE_W;  // see RL8
  localparam int SW    = CLK_PINS + CTRL_PINS + ADDR_W + LANES + DATA_W;

  logic [SW-1:0]       meta_q;
  logic [SW-1:0]       sync_q;
  logic [CLK_PINS-1:0] clk_prev_q;
  logic                kp_s;
  logic                kn_s;
  logic                cp_s;
  logic                cn_s;
  logic                load_s;
  logic                rnw_s;
  logic [ADDR_W-1:0]   addr_s;
  logic [LANES-1:0]    we_n_s;
  logic [DATA_W-1:0]   dq_s;

  // Clocks and data share one delay so the edge still frames its data
  always_ff @(posedge sys_clk) begin
    meta_q     <= {input_strobe_p, input_strobe_n, output_strobe_p,
                   output_strobe_n, load_n, read_not_write, addr_in,
                   burst_low_bit, lane_write_en_n, dq_in};
    sync_q     <= meta_q;
    clk_prev_q <= sync_q[SW-1 -: CLK_PINS];
  end

  assign {kp_s, kn_s, cp_s, cn_s, load_s, rnw_s, addr_s, we_n_s, dq_s} =
    sync_q;

  logic k_rise;
  logic kn_rise;
  logic cp_rise;
  logic cn_rise;
  logic cmode;
  logic p_ev;
  logic n_ev;
  logic ref_p;
  logic ref_n;

  assign k_rise  = kp_s & ~clk_prev_q[3];
  assign kn_rise = kn_s & ~clk_prev_q[2];
  assign cp_rise = cp_s & ~clk_prev_q[1];
  assign cn_rise = cn_s & ~clk_prev_q[0];
  // Both output clocks high selects the input clocks as reference
  assign cmode   = ~(cp_s & cn_s);                 // see RL11
  // Memory data is ready one cycle after the load edge, so K mode can
  // launch the first word right away
  assign p_ev    = cmode ? cp_rise : 1'b1;         // see RL6 RL11
  assign n_ev    = cmode ? cn_rise : kn_rise;      // see RL6 RL11
  assign ref_p   = cmode ? cp_s : kp_s;
  assign ref_n   = cmode ? cn_s : kn_s;

  // ****************************************************************
  // Bus cycle state machine
  // ****************************************************************
  bus_state_e        state_q;
  bus_state_e        state_d;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] base_d;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] dq_out_q;
  logic [DATA_W-1:0] dq_out_d;
  logic              oe_q;
  logic              oe_d;
  logic              echo_p_q;
  logic              echo_n_q;
  logic              wr_en;
  logic [LANES-1:0]  wr_lane_en;
  logic [ADDR_W-1:0] wr_addr;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;

  assign next_addr = {base_q[ADDR_W-1:1], ~base_q[0]};  // see RL1

  always_comb begin
    state_d    = state_q;
    base_d     = base_q;
    dq_out_d   = dq_out_q;
    oe_d       = oe_q;
    wr_en      = 1'b0;
    wr_addr    = next_addr;
    wr_lane_en = ~we_n_s;                            // see RL12
    rd_en      = 1'b0;
    rd_addr    = next_addr;
    unique case (state_q)
      ST_IDLE: begin
        if (k_rise) begin                            // see RL3
          if (!load_s) begin                         // see RL4
            base_d = addr_s;                         // see RL13
            if (rnw_s) begin
              rd_en   = 1'b1;
              rd_addr = addr_s;
              state_d = ST_RD1;
            end else begin
              wr_en   = 1'b1;                        // see RL5
              wr_addr = addr_s;
              oe_d    = 1'b0;
              state_d = ST_WR2;
            end
          end else begin
            oe_d = 1'b0;                             // see RL9
          end
        end
      end
      ST_WR2: begin
        if (kn_rise) begin
          wr_en   = 1'b1;                            // see RL5 RL1
          state_d = ST_IDLE;                         // see RL2
        end
      end
      ST_RD1: begin
        if (p_ev) begin
          dq_out_d = rd_data;                        // see RL6
          oe_d     = 1'b1;
          rd_en    = 1'b1;
          state_d  = ST_RD2;
        end
      end
      ST_RD2: begin
        if (n_ev) begin
          dq_out_d = rd_data;                        // see RL6
          state_d  = ST_IDLE;                        // see RL2
        end
      end
    endcase
  end

  // Stopped clocks give no edges, so every register holds, except that a K-mode read in ST_RD1 still advances
  always_ff @(posedge sys_clk) begin                 // see RL10
    if (sys_rst) begin
      state_q  <= ST_IDLE;
      base_q   <= '0;
      dq_out_q <= '0;
      oe_q     <= 1'b0;
      echo_p_q <= 1'b0;
      echo_n_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      base_q   <= base_d;
      dq_out_q <= dq_out_d;
      oe_q     <= oe_d;
      echo_p_q <= ref_p;                             // see RL7
      echo_n_q <= ref_n;                             // see RL7
    end
  end

  assign dq_out          = dq_out_q;
  assign dq_oe           = oe_q;
  assign return_strobe_p = echo_p_q;
  assign return_strobe_n = echo_n_q;

  // ****************************************************************
  // Storage
  // ****************************************************************
  burst_lane_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_mem (
    .sys_clk    (sys_clk),
    .wr_en      (wr_en),
    .wr_lane_en (wr_lane_en),
    .wr_addr    (wr_addr),
    .wr_data    (dq_s),
    .rd_en      (rd_en),
    .rd_addr    (rd_addr),
    .rd_data_q  (rd_data)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence idle_load_s;
    state_q == ST_IDLE && k_rise && !load_s;
  endsequence
  sequence rd_last_s;
    state_q == ST_RD2 && n_ev;
  endsequence

  burst_flip_a: assert property (state_q == ST_WR2 && kn_rise |->  // see RL1
    wr_en && wr_addr == {base_q[ADDR_W-1:1], ~base_q[0]})
    else $error("second write address not flipped");
  burst_end_a: assert property (rd_last_s |=> state_q == ST_IDLE)  // see RL2
    else $error("read cycle did not end after two words");
  edge_only_a: assert property (state_q == ST_IDLE && !k_rise |=>  // see RL3
    state_q == ST_IDLE && $stable(base_q))
    else $error("cycle started without input clock rise");
  read_start_a: assert property (idle_load_s ##0 rnw_s |=>  // see RL4
    state_q == ST_RD1 && base_q == $past(addr_s))
    else $error("read load not taken");
  write_first_a: assert property (idle_load_s ##0 !rnw_s |->  // see RL5
    wr_en && wr_addr == addr_s ##1 state_q == ST_WR2)
    else $error("first write word not stored");
  read_second_a: assert property (rd_last_s |=>  // see RL6
    dq_out == $past(rd_data) && dq_oe)
    else $error("second read word not driven");
  echo_run_a: assert property (!$stable(ref_p) |=>  // see RL7
    !$stable(return_strobe_p))
    else $error("echo clock stalled");
  nop_float_a: assert property (state_q == ST_IDLE && k_rise && load_s  // see RL9
    |=> !dq_oe ##1 (!dq_oe || state_q != ST_IDLE))
    else $error("data pins driven during no-operation");
  stop_hold_a: assert property (state_q != ST_RD1 && !k_rise && !kn_rise  // see RL10
    && !cp_rise && !cn_rise |=> $stable(state_q) && $stable(dq_out))
    else $error("state moved without clock edges");
  kmode_wait_a: assert property (state_q == ST_RD2 && !cmode && !kn_rise  // see RL11
    |=> state_q == ST_RD2)
    else $error("K-mode read ignored input clock");
  lane_gate_a: assert property (wr_en |-> wr_lane_en == ~we_n_s)  // see RL12
    else $error("lane enable not honoured");
  addr_hold_a: assert property (state_q != ST_IDLE |=> $stable(base_q))  // see RL13
    else $error("address reloaded during burst");

endmodule

//--- src/ddr_burst2_pkg.sv
// Shared constants for the two-word burst DDR SRAM bus cycle logic
// Operation
// RL1: Second burst address is the first with its lowest bit inverted.
// RL2: Every bus cycle moves exactly two words, then ends.
// RL3: State machine advances and samples commands only on input clock rise; code also advances bursts on input strobe n and output strobe rises.
// RL4: Load low starts a cycle; read_not_write picks read or write.
// RL5: Write words arrive at input strobe p rise, then input strobe n rise.
// RL6: Read words leave at output strobe p rise, then output strobe n rise.
// RL7: Echo clock pair toggles continuously, even while data pins float.
// RL8: Data bus is 18 or 36 bits wide.
// RL9: Load high is a no-operation; data pins float for both slots.
// RL10: With the input clock stopped, pins hold and nothing advances; a K-mode read still leaves ST_RD1 and drives its first word.
// RL11: Output strobes both held high means read data follows input clocks.
// RL12: Each active-low lane enable gates its 9-bit lane per data edge.
// RL13: Address inputs are registered only at the loading edge.
package ddr_burst2_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int LANE_W     = 9;
  localparam int DATA_W_DEF = 18;
  localparam int ADDR_W_DEF = 10;
  localparam int CLK_PINS   = 4;
  localparam int CTRL_PINS  = 2;

  // ****************************************************************
  // Bus cycle states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WR2,
    ST_RD1,
    ST_RD2
  } bus_state_e;

endpackage

//--- src/burst_lane_mem.sv
// Lane-gated storage array with registered read data
`timescale 1ns/1ns
module burst_lane_mem #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 10,
  parameter int LANES  = 2,
  parameter int LANE_W = 9
) (
  input  wire logic              sys_clk,     // System clock
  input  wire logic              wr_en,       // Write strobe
  input  wire logic [LANES-1:0]  wr_lane_en,  // Per-lane write enable
  input  wire logic [ADDR_W-1:0] wr_addr,     // Write address
  input  wire logic [DATA_W-1:0] wr_data,     // Write data
  input  wire logic              rd_en,       // Read strobe
  input  wire logic [ADDR_W-1:0] rd_addr,     // Read address
  output logic      [DATA_W-1:0] rd_data_q    // Registered read data
);

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      logic [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
      always_ff @(posedge sys_clk) begin
        if (wr_en && wr_lane_en[g]) begin
          mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
        end
        if (rd_en) begin
          rd_data_q[g*LANE_W +: LANE_W] <= mem[rd_addr];
        end
      end
    end
  endgenerate

endmodule

//--- test/ctrl_model.sv
// Memory controller model driving the burst SRAM pins
`timescale 1ns/1ns
module ctrl_model (
  input  wire logic        sys_clk, // Clock
  input  wire logic        k_mode,  // C pair held high
  input  wire logic [17:0] dq_out,  // Device data
  input  wire logic        dq_oe,   // Device enable
  input  wire logic        echo_p,  // Echo clock
  output logic             k_p,     // K clock
  output logic             k_n,     // K compl.
  output logic             c_p,     // C clock
  output logic             c_n,     // C compl.
  output logic             load_n,  // Load, low
  output logic             rnw,     // Read not write
  output logic [8:0]       addr,    // Upper address
  output logic             low_bit, // Low address bit
  output logic [1:0]       lane_n,  // Lane enables
  output logic [17:0]      dq_in    // Wire level
);
  logic [17:0] wd, q0, q1;
  logic        wr, pat_q, oe0, oe1, e0, e1;
  // ****
  // Wire and clock phases
  // ****
  // Floating lines toggle so a stale value never reads as a match
  assign dq_in = dq_oe ? dq_out : (wr ? wd : {18{pat_q}});
  initial begin
    {k_p, k_n, c_p, c_n, wr, pat_q} = 6'h14;
    {load_n, rnw, addr, low_bit, lane_n, wd} = '1;
  end
  always @(posedge sys_clk) pat_q <= ~pat_q;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One K period; pins stay 4 clocks either side of each K edge, write data only 3 after the second
  task automatic cycle(input logic ld, rd, input logic [9:0] a,
    input logic [17:0] d0, d1, input logic [1:0] b0, b1);
    if (k_mode) {c_p, c_n} = 2'h3;
    {load_n, rnw, addr, low_bit} = {ld, rd, a};
    {wd, lane_n, wr} = {d0, b0, !ld && !rd};
    tick(4);
    {k_p, k_n, q1, oe1, e1} = {2'h2, dq_out, dq_oe, echo_p};
    tick(2);
    if (!k_mode) {c_p, c_n} = 2'h2;
    tick(2);
    // Junk after the load edge must not be taken
    {load_n, rnw, addr, low_bit} = ~{ld, rd, a};
    {wd, lane_n} = {d1, b1};
    tick(4);
    {k_p, k_n, q0, oe0, e0} = {2'h1, dq_out, dq_oe, echo_p};
    tick(2);
    if (!k_mode) {c_p, c_n} = 2'h1;
    tick(1);
    // Release write data a clock early so back-to-back calls never clash
    wr = 0;
    tick(1);
  endtask
endmodule

//--- test/tb_top.sv
// Testbench for the burst SRAM bus cycle logic
`timescale 1ns/1ns
module tb_top;
  logic        sys_clk, sys_rst, k_mode, dq_oe, echo_p, echo_n;
  logic        k_p, k_n, c_p, c_n, load_n, rnw, low_bit;
  logic [8:0]  addr;
  logic [1:0]  lane_n;
  logic [17:0] dq_in, dq_out;
  int          errors, total_checks;
  always #4 sys_clk = ~sys_clk;
  ddr_sram_burst2_bus_cycle i_ddr_sram_burst2_bus_cycle (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .input_strobe_p(k_p),
    .input_strobe_n(k_n), .output_strobe_p(c_p), .output_strobe_n(c_n),
    .load_n(load_n), .read_not_write(rnw), .addr_in(addr),
    .burst_low_bit(low_bit), .lane_write_en_n(lane_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .return_strobe_p(echo_p),
    .return_strobe_n(echo_n));
  ctrl_model i_ctrl_model (
    .sys_clk(sys_clk), .k_mode(k_mode), .dq_out(dq_out), .dq_oe(dq_oe),
    .echo_p(echo_p), .k_p(k_p), .k_n(k_n), .c_p(c_p), .c_n(c_n),
    .load_n(load_n), .rnw(rnw), .addr(addr), .low_bit(low_bit),
    .lane_n(lane_n), .dq_in(dq_in));
  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [17:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [17:0] d0, d1,
    input logic [1:0] b0, b1);
    i_ctrl_model.cycle(1'b0, 1'b0, a, d0, d1, b0, b1);
  endtask
  // Read, then a NOP that also collects the second word
  task automatic rd(input logic [9:0] a, input logic [17:0] x0, x1);
    logic [17:0] w0;
    logic        oe, ec;
    i_ctrl_model.cycle(1'b0, 1'b1, a, '0, '0, 2'h3, 2'h3);
    w0 = i_ctrl_model.q0;
    oe = i_ctrl_model.oe0;
    ec = i_ctrl_model.e0;
    i_ctrl_model.cycle(1'b1, 1'b0, a, '0, '0, 2'h3, 2'h3);
    check("word0", w0, x0);
    check("word1", i_ctrl_model.q1, x1);
    check("read oe", {17'h0, oe & i_ctrl_model.oe1}, 18'h1);
    check("nop oe", {17'h0, i_ctrl_model.oe0}, 18'h0);
    check("echo", {16'h0, ec, i_ctrl_model.e0}, 18'h3);
    check("echo low", {17'h0, i_ctrl_model.e1}, 18'h0);
  endtask
  task automatic test_burst();
    wr(10'h054, 18'h1a2b3, 18'h2c4d5, 2'h0, 2'h0);
    rd(10'h054, 18'h1a2b3, 18'h2c4d5);
    rd(10'h055, 18'h2c4d5, 18'h1a2b3);
    $display("test_burst done");
  endtask
  task automatic test_lanes();
    wr(10'h0a0, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
    wr(10'h0a0, 18'h00000, 18'h00000, 2'h2, 2'h1);
    rd(10'h0a0, 18'h3fe00, 18'h001ff);
    $display("test_lanes done");
  endtask
  task automatic test_kmode();
    k_mode = 1;
    rd(10'h055, 18'h2c4d5, 18'h1a2b3);
    k_mode = 0;
    $display("test_kmode done");
  endtask
  task automatic test_stop();
    wr(10'h1f0, 18'h0beef, 18'h3cafe, 2'h0, 2'h0);
    i_ctrl_model.cycle(1'b0, 1'b1, 10'h1f0, '0, '0, 2'h3, 2'h3);
    i_ctrl_model.tick(40);
    check("held data", dq_out, 18'h3cafe);
    check("held oe", {17'h0, dq_oe}, 18'h1);
    check("echo pair", {16'h0, echo_p, echo_n}, 18'h1);
    rd(10'h1f1, 18'h3cafe, 18'h0beef);
    $display("test_stop done");
  endtask
  // ****
  // Sequence and watchdog
  // ****
  initial begin
    {sys_clk, sys_rst, k_mode} = 3'h2;
    errors = 0;
    total_checks = 0;
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 0;
    test_burst();
    test_lanes();
    test_kmode();
    test_stop();
    end_of_test();
  end
  // Run needs about 290 clocks
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule
